//--- hdl/motion_cmd_device.sv
// Command decoder and per-axis parameter store of the motion device.
//
// Contract
// RULE1 - Decode data-read codes 10h to 14h.
// RULE2 - Decode driving codes 20h to 27h.
// RULE3 - Start interpolation on 30h, 32h-34h.
// RULE4 - Step-pattern enable, disable, push, clear.
// RULE5 - Decode 3Ah-3Eh step, decel, clears.
// RULE6 - Host never sends undefined codes.
// RULE7 - Several assigned axes load together.
// RULE8 - Host fills data words, then command.
// RULE9 - Data is binary, two's complement.
// RULE10 - Out-of-range parameter blocks the drive.
// RULE11 - No new command within accept time.
// RULE12 - Only offset has reset value; load others. The code also resets range and the other parameters.
// RULE13 - Range 00h; multiple is 8e6 over range.
// RULE14 - Host keeps range during drives.
// RULE15 - Jerk 01h: 62.5e6 over K, times multiple.
// RULE16 - Accel 02h: value times 125 times multiple.
// RULE17 - S-curve ramps acceleration up linearly.
// RULE18 - Decel 03h used only in separate mode.
// RULE19 - Separate S-curve ramps deceleration linearly.
// RULE20 - Initial speed 04h: value times multiple.
// RULE21 - Host keeps fixed S-curve initial speed above 100. The host still sends 100 or less and only sets ST_LOWSV.
// RULE22 - Drive speed below initial: constant speed.
// RULE23 - Read result split low and high words.
// RULE24 - Only assigned axes take the command.
`timescale 1ns/1ps
`default_nettype none
`include "motion_regs.svh"
module motion_cmd_device import motion_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the controller.
  motion_bus_if.dev bus,
  // Per-axis state to read back, axis 0 is X.
  input wire logic [1:0][31:0] commanded_position_count,
  input wire logic [1:0][31:0] encoder_position_count,
  input wire logic [1:0][15:0] current_speed_value,
  input wire logic [1:0][15:0] current_accel_value,
  input wire logic [31:0] peak_endpoint_value,
  // S-curve ramp pacing from the pulse generator.
  input wire logic [1:0] ramp_step,
  input wire logic [1:0] ramp_clear,
  input wire logic [1:0] ramp_decel,
  // Scaled profile values per axis.
  output logic [1:0][31:0] speed_multiple,
  output logic [1:0][35:0] jerk_rate,
  output logic [1:0][31:0] accel_rate,
  output logic [1:0][31:0] decel_rate,
  output logic [1:0][31:0] start_velocity,
  output logic [1:0][15:0] drive_speed,
  output logic [1:0][15:0] accel_count_offset,
  output logic [1:0][15:0] ramp_value,
  output logic [1:0] constant_speed,
  output logic [1:0] drive_ok,
  // Command pulses and mode levels to the motion engine.
  output logic drive_go,
  output logic [2:0] drive_op,
  output logic [1:0] drive_axes,
  output logic interp_go,
  output logic [1:0] interp_op,
  output logic interp_step,
  output logic pattern_push,
  output logic pattern_clear,
  output logic pattern_wr_en,
  output logic decel_enable,
  output logic interp_irq_clear,
  output logic peak_clear
);
  // Stored data words and mode register.
  logic [15:0] dlow_q;
  logic [15:0] dhigh_q;
  logic [15:0] mode3_q;
  // Accept timer; nonzero while a command is being taken.
  logic [4:0] busy_q;
  // Latched read result.
  logic [31:0] read_q;
  // Per-axis raw parameters.
  logic [1:0][31:0] range_q;
  logic [1:0][15:0] jerk_q;
  logic [1:0][15:0] accel_q;
  logic [1:0][15:0] decel_q;
  logic [1:0][15:0] svel_q;
  logic [1:0][5:0] bad_q;
  // Decode wires.
  wire take = bus.wr_stb && bus.wr_addr == `WADDR_CMD && busy_q == 5'd0;
  wire [7:0] code = bus.wr_data[`CMD_CODE_MSB:0];
  wire [1:0] axes = bus.wr_data[`CMD_AXIS_LSB+1:`CMD_AXIS_LSB];
  wire [31:0] dword = {dhigh_q, dlow_q};
  wire is_read = code >= `C_RD_LP && code <= `C_RD_MX; // RULE1
  wire is_drive = code >= `C_DRV_FIRST && code <= `C_DRV_LAST; // RULE2
  wire is_interp = code >= `C_IP_LIN && code <= `C_IP_PAT &&
                   code != `C_IP_GAP; // RULE3
  wire rd_axis = ~axes[0]; // X wins when both axes are assigned.
  wire range_bad = dword < `RANGE_MIN || dword > `RANGE_MAX;
  wire speed_bad = dlow_q == 16'h0000 || dlow_q > `SPEED_MAX;
  logic [31:0] read_d;

  // Link read port shows the low or high half of the result.
  assign bus.rd_data = bus.rd_addr ? read_q[31:16] : read_q[15:0]; // RULE23
  assign bus.busy = busy_q != 5'd0;

  // Data-read source selection for the assigned axis.
  always_comb begin
    unique case (code)
      `C_RD_LP: read_d = commanded_position_count[rd_axis]; // RULE1
      `C_RD_EP: read_d = encoder_position_count[rd_axis];
      `C_RD_CV: read_d = {16'h0000, current_speed_value[rd_axis]};
      `C_RD_CA: read_d = {16'h0000, current_accel_value[rd_axis]};
      default: read_d = peak_endpoint_value;
    endcase
  end

  // Data and mode words, taken raw as two's complement.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlow_q <= 16'h0000;
      dhigh_q <= 16'h0000;
      mode3_q <= 16'h0000;
    end else if (bus.wr_stb) begin
      if (bus.wr_addr == `WADDR_DLOW) dlow_q <= bus.wr_data; // RULE9
      if (bus.wr_addr == `WADDR_DHIGH) dhigh_q <= bus.wr_data; // RULE9
      if (bus.wr_addr == `WADDR_MODE3) mode3_q <= bus.wr_data;
    end
  end

  // Accept timer; commands arriving while it runs are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 5'd0;
    end else if (take) begin
      busy_q <= 5'(`CMD_ACCEPT_CYC); // RULE11
    end else if (busy_q != 5'd0) begin
      busy_q <= busy_q - 5'd1;
    end
  end

  // Read result latched when a read code is taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_q <= 32'h0000_0000;
    end else if (take && is_read) begin
      read_q <= read_d; // RULE23
    end
  end

  // Command pulses and mode levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_go <= 1'b0;
      drive_op <= 3'd0;
      drive_axes <= 2'b00;
      interp_go <= 1'b0;
      interp_op <= 2'd0;
      interp_step <= 1'b0;
      pattern_push <= 1'b0;
      pattern_clear <= 1'b0;
      pattern_wr_en <= 1'b0;
      decel_enable <= 1'b1;
      interp_irq_clear <= 1'b0;
      peak_clear <= 1'b0;
    end else begin
      drive_go <= take && is_drive && (axes & drive_ok) != 2'b00; // RULE2
      interp_go <= take && is_interp && drive_ok == 2'b11; // RULE3
      interp_step <= take && code == `C_IP_STEP; // RULE5
      pattern_push <= take && code == `C_BP_PUSH; // RULE4
      pattern_clear <= take && code == `C_BP_CLR; // RULE4
      interp_irq_clear <= take && code == `C_IP_IRQCLR; // RULE5
      peak_clear <= take && code == `C_MX_CLR; // RULE5
      // Only axes with valid parameters may be driven.
      if (take && is_drive) begin
        drive_op <= code[2:0];
        drive_axes <= axes & drive_ok; // RULE10
      end
      // Interpolation kind: linear, cw, ccw, pattern.
      if (take && is_interp) begin
        interp_op <= code == `C_IP_LIN ? 2'd0 : code[1:0] + 2'd3; // RULE3
      end
      // Pattern write gate and deceleration switch stay as levels.
      if (take && code == `C_BP_EN) pattern_wr_en <= 1'b1; // RULE4
      if (take && code == `C_BP_DIS) pattern_wr_en <= 1'b0; // RULE4
      if (take && code == `C_DEC_EN) decel_enable <= 1'b1; // RULE5
      if (take && code == `C_DEC_DIS) decel_enable <= 1'b0; // RULE5
    end
  end

  // One copy of the parameter store per axis.
  for (genvar a = 0; a < 2; a++) begin : g_axis
    // The same data lands in every assigned axis in one edge.
    wire ld = take && axes[a]; // RULE7 RULE24

    // Parameter registers; all reset, the offset to ACCOFS_RESET, range to RANGE_MAX, bad flags to 0, the rest to 1.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        range_q[a] <= `RANGE_MAX;
        jerk_q[a] <= 16'h0001;
        accel_q[a] <= 16'h0001;
        decel_q[a] <= 16'h0001;
        svel_q[a] <= 16'h0001;
        drive_speed[a] <= 16'h0001;
        accel_count_offset[a] <= `ACCOFS_RESET; // RULE12
        bad_q[a] <= 6'b00_0000;
      end else if (ld) begin
        unique case (code)
          `C_RANGE: begin
            range_q[a] <= dword; // RULE13
            bad_q[a][0] <= range_bad; // RULE10
          end
          `C_JERK: begin
            jerk_q[a] <= dlow_q; // RULE15
            bad_q[a][1] <= dlow_q == 16'h0000; // RULE10
          end
          `C_ACCEL: begin
            accel_q[a] <= dlow_q; // RULE16
            bad_q[a][2] <= speed_bad; // RULE10
          end
          `C_DECEL: begin
            decel_q[a] <= dlow_q; // RULE18
            bad_q[a][3] <= speed_bad; // RULE10
          end
          `C_SVEL: begin
            svel_q[a] <= dlow_q; // RULE20
            bad_q[a][4] <= speed_bad; // RULE10
          end
          `C_DSPEED: begin
            drive_speed[a] <= dlow_q; // RULE22
            bad_q[a][5] <= speed_bad; // RULE10
          end
          `C_ACCOFS: accel_count_offset[a] <= dlow_q; // RULE12
          default: ;
        endcase
      end
    end

    // Scaled rates; a bad range is still stored and used as the divisor.
    assign speed_multiple[a] = 32'(`RANGE_MAX / range_q[a]); // RULE13
    assign jerk_rate[a] = 36'((`JERK_NUM / 36'(jerk_q[a])) *
                              36'(speed_multiple[a])); // RULE15
    assign accel_rate[a] = 32'(accel_q[a] * `ACCEL_SCALE *
                               speed_multiple[a]); // RULE16
    // Separate deceleration only when the mode bit is set.
    assign decel_rate[a] = mode3_q[`MODE3_SEPDEC] ?
        32'(decel_q[a] * `ACCEL_SCALE * speed_multiple[a]) :
        accel_rate[a]; // RULE18
    assign start_velocity[a] = 32'(svel_q[a] * speed_multiple[a]); // RULE20
    assign constant_speed[a] = drive_speed[a] < svel_q[a]; // RULE22
    assign drive_ok[a] = bad_q[a] == 6'b00_0000; // RULE10

    // Linear S-curve ramp from zero toward the selected limit.
    wire [15:0] ramp_lim = (ramp_decel[a] && mode3_q[`MODE3_SEPDEC]) ?
                           decel_q[a] : accel_q[a]; // RULE19
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ramp_value[a] <= 16'h0000;
      end else if (ramp_clear[a]) begin
        ramp_value[a] <= 16'h0000;
      end else if (ramp_step[a] && ramp_value[a] < ramp_lim) begin
        ramp_value[a] <= ramp_value[a] + 16'h0001; // RULE17 RULE19
      end
    end
  end
endmodule : motion_cmd_device
`default_nettype wire

//--- pkg/motion_regs.svh
// Constants for the motion command link and the controller registers.
`ifndef MOTION_REGS_SVH
`define MOTION_REGS_SVH
// Link write addresses seen by the device.
`define WADDR_CMD 2'h0
`define WADDR_DLOW 2'h1
`define WADDR_DHIGH 2'h2
`define WADDR_MODE3 2'h3
// Command word fields.
`define CMD_CODE_MSB 7
`define CMD_AXIS_LSB 8
// Parameter-write codes.
`define C_RANGE 8'h00
`define C_JERK 8'h01
`define C_ACCEL 8'h02
`define C_DECEL 8'h03
`define C_SVEL 8'h04
`define C_DSPEED 8'h05
`define C_PULSES 8'h06
`define C_COMPM 8'h0C
`define C_ACCOFS 8'h0D
`define C_NOP 8'h0F
// Data-read codes.
`define C_RD_LP 8'h10
`define C_RD_EP 8'h11
`define C_RD_CV 8'h12
`define C_RD_CA 8'h13
`define C_RD_MX 8'h14
// Driving codes.
`define C_DRV_FIRST 8'h20
`define C_DRV_LAST 8'h27
// Interpolation and pattern codes.
`define C_IP_LIN 8'h30
`define C_IP_GAP 8'h31
`define C_IP_CW 8'h32
`define C_IP_CCW 8'h33
`define C_IP_PAT 8'h34
`define C_IP_GAP2 8'h35
`define C_BP_EN 8'h36
`define C_BP_DIS 8'h37
`define C_BP_PUSH 8'h38
`define C_BP_CLR 8'h39
`define C_IP_STEP 8'h3A
`define C_DEC_EN 8'h3B
`define C_DEC_DIS 8'h3C
`define C_IP_IRQCLR 8'h3D
`define C_MX_CLR 8'h3E
// Parameter limits and scale factors.
`define RANGE_MIN 32'h0000_3E80
`define RANGE_MAX 32'h007A_1200
`define SPEED_MAX 16'h1F40
`define JERK_NUM 36'h0_03B9_ACA0
`define ACCEL_SCALE 32'h0000_007D
`define SV_WARN 16'h0064
`define ACCOFS_RESET 16'h0008
`define MODE3_SEPDEC 1
// Command accept time: longest time, rounded down to cycles.
`define CMD_ACCEPT_NS 250
`define CLK_PERIOD_NS 10
`define CMD_ACCEPT_CYC (`CMD_ACCEPT_NS / `CLK_PERIOD_NS)
// Controller APB byte offsets.
`define A_DATA 12'h000
`define A_CMD 12'h004
`define A_MODE3 12'h008
`define A_RDATA 12'h00C
`define A_STATUS 12'h010
// Controller status bits.
`define ST_BUSY 0
`define ST_ILLEGAL 1
`define ST_RANGE 2
`define ST_NOTLOADED 3
`define ST_LOWSV 4
`endif

//--- pkg/motion_pkg.sv
// Types shared by the motion command device and its controller.
`default_nettype none
package motion_pkg;
  // Controller sequencing states.
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LO = 3'b001,
    S_HI = 3'b010,
    S_CMD = 3'b011,
    S_WAIT = 3'b100,
    S_RLO = 3'b101,
    S_RHI = 3'b110,
    S_MODE = 3'b111
  } host_state_e;
  // One 16-bit parameter word.
  typedef logic [15:0] word_t;
endpackage : motion_pkg
`default_nettype wire

//--- pkg/motion_bus_if.sv
// Parallel register link between the controller and the motion device.
`timescale 1ns/1ps
`default_nettype none
interface motion_bus_if;
  logic wr_stb;         // One-cycle write strobe.
  logic [1:0] wr_addr;  // Which write register.
  logic [15:0] wr_data; // Write data.
  logic rd_addr;        // 0 selects low read word, 1 high.
  logic [15:0] rd_data; // Read word from the device.
  logic busy;           // Device still accepting a command.
  modport dev (input wr_stb, input wr_addr, input wr_data, input rd_addr,
               output rd_data, output busy);
  modport host (output wr_stb, output wr_addr, output wr_data,
                output rd_addr, input rd_data, input busy);
endinterface : motion_bus_if
`default_nettype wire

//--- hdl/motion_cmd_host.sv
// APB-controlled sequencer that issues commands to the motion device.
`timescale 1ns/1ps
`default_nettype none
`include "motion_regs.svh"
module motion_cmd_host import motion_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motion engine state.
  input wire logic drive_active,
  // Link to the device.
  motion_bus_if.host bus
);
  host_state_e state_q;
  logic [31:0] data_q;     // Parameter data to send.
  logic [15:0] cmd_q;      // Axis bits and code to send.
  logic [15:0] mode3_q;    // Mode word to send.
  logic [31:0] rdata_q;    // Last read result.
  logic [4:1] err_q;       // Sticky status bits.
  logic [3:0] loaded_q;    // Range, accel, start, speed loaded.
  logic [4:0] wait_q;      // Accept-time countdown.
  // APB decode.
  wire acc = psel && penable;
  wire idle = state_q == S_IDLE;
  wire hit_data = paddr == `A_DATA;
  wire hit_cmd = paddr == `A_CMD;
  wire hit_mode = paddr == `A_MODE3;
  wire hit_rd = paddr == `A_RDATA;
  wire hit_st = paddr == `A_STATUS;
  wire mapped = hit_data || hit_cmd || hit_mode || hit_rd || hit_st;
  wire done = acc && pready;
  wire [7:0] c = pwdata[7:0];
  wire legal = c <= `C_ACCOFS || c == `C_NOP ||
      (c >= `C_RD_LP && c <= `C_RD_MX) ||
      (c >= `C_DRV_FIRST && c <= `C_DRV_LAST) ||
      (c >= `C_IP_LIN && c <= `C_MX_CLR && c != `C_IP_GAP &&
       c != `C_IP_GAP2);
  wire four = c == `C_RANGE || (c >= `C_PULSES && c <= `C_COMPM);
  wire two = c != `C_RANGE && !four && c <= `C_ACCOFS;
  wire bad_val = (c == `C_RANGE && (data_q < `RANGE_MIN ||
      data_q > `RANGE_MAX)) || (c == `C_JERK && data_q[15:0] == 16'h0000) ||
      (c >= `C_ACCEL && c <= `C_DSPEED && (data_q[15:0] == 16'h0000 ||
      data_q[15:0] > `SPEED_MAX));
  wire range_live = c == `C_RANGE && drive_active;
  wire not_loaded = c >= `C_DRV_FIRST && c <= `C_IP_PAT &&
      loaded_q != 4'hF;
  wire refuse = !legal || bad_val || range_live || not_loaded;
  wire issue = done && pwrite && hit_cmd && !refuse;
  wire is_read = cmd_q[7:0] >= `C_RD_LP && cmd_q[7:0] <= `C_RD_MX;

  // Writes stall in the access phase until the sequencer is idle.
  assign pready = !pwrite || idle;
  assign pslverr = acc && !mapped;
  // Read mux, zero for unmapped offsets.
  assign prdata = hit_data ? data_q : hit_cmd ? {16'h0000, cmd_q} :
      hit_mode ? {16'h0000, mode3_q} : hit_rd ? rdata_q :
      hit_st ? {27'd0, err_q, !idle} : 32'h0000_0000;
  // Link drive from the sequencer state.
  assign bus.wr_stb = state_q == S_LO || state_q == S_HI ||
      state_q == S_CMD || state_q == S_MODE;
  assign bus.wr_addr = state_q == S_LO ? `WADDR_DLOW :
      state_q == S_HI ? `WADDR_DHIGH :
      state_q == S_MODE ? `WADDR_MODE3 : `WADDR_CMD;
  assign bus.wr_data = state_q == S_LO ? data_q[15:0] :
      state_q == S_HI ? data_q[31:16] :
      state_q == S_MODE ? mode3_q : cmd_q;
  assign bus.rd_addr = state_q == S_RHI;

  // Software registers and status; a new error wins over its clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 32'h0000_0000;
      cmd_q <= 16'h0000;
      mode3_q <= 16'h0000;
      err_q <= 4'h0;
      loaded_q <= 4'h0;
    end else if (done && pwrite) begin
      if (hit_data) data_q <= pwdata; // RULE9
      if (hit_mode) mode3_q <= pwdata[15:0];
      if (hit_cmd && !refuse) cmd_q <= pwdata[15:0];
      if (hit_st) err_q <= err_q & ~pwdata[4:1];
      if (hit_cmd) begin
        if (!legal) err_q[`ST_ILLEGAL] <= 1'b1; // RULE6
        if (bad_val || range_live) err_q[`ST_RANGE] <= 1'b1; // RULE10 RULE14
        if (not_loaded) err_q[`ST_NOTLOADED] <= 1'b1; // RULE12
        if (!refuse && c == `C_SVEL && data_q[15:0] <= `SV_WARN)
          err_q[`ST_LOWSV] <= 1'b1; // RULE21
        if (!refuse && c == `C_RANGE) loaded_q[0] <= 1'b1; // RULE12
        if (!refuse && c == `C_ACCEL) loaded_q[1] <= 1'b1;
        if (!refuse && c == `C_SVEL) loaded_q[2] <= 1'b1;
        if (!refuse && c == `C_DSPEED) loaded_q[3] <= 1'b1;
      end
    end
  end

  // Sequencer: data words, command, accept wait, optional read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      wait_q <= 5'd0;
      rdata_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (issue && two) state_q <= S_LO; // RULE8
          else if (issue && four) state_q <= S_LO; // RULE8
          else if (issue) state_q <= S_CMD;
          else if (done && pwrite && hit_mode) state_q <= S_MODE;
        end
        S_LO: state_q <= cmd_q[7:0] == `C_RANGE ||
            (cmd_q[7:0] >= `C_PULSES && cmd_q[7:0] <= `C_COMPM) ?
            S_HI : S_CMD; // RULE8
        S_HI: state_q <= S_CMD;
        S_CMD: begin
          wait_q <= 5'(`CMD_ACCEPT_CYC); // RULE11
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (wait_q != 5'd0) wait_q <= wait_q - 5'd1;
          else if (!bus.busy) state_q <= is_read ? S_RLO : S_IDLE; // RULE11
        end
        S_RLO: begin
          rdata_q[15:0] <= bus.rd_data;
          state_q <= S_RHI;
        end
        S_RHI: begin
          rdata_q[31:16] <= bus.rd_data;
          state_q <= S_IDLE;
        end
        S_MODE: state_q <= S_IDLE;
      endcase
    end
  end
endmodule : motion_cmd_host
`default_nettype wire

//--- test/motion_cmd_asserts.sv
// Link timing checks between the command sequencer and the motion device.
`timescale 1ns/1ps
`default_nettype none
module motion_cmd_asserts (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link signals, as seen on the interface.
  input wire logic wr_stb,
  input wire logic [1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic busy
);
  // Counts consecutive busy cycles to measure the accept window.
  logic [5:0] bcnt_q;
  // A command word that the device takes.
  wire take = wr_stb && (wr_addr == 2'h0) && !busy;
  // The count restarts whenever busy is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= 6'h00;
    end else begin
      bcnt_q <= busy ? bcnt_q + 6'h01 : 6'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  busy_start_a: assert property (take |=> busy)
    else $error("busy did not follow a command");
  busy_cause_a: assert property ($rose(busy) |-> $past(take))
    else $error("busy rose without a command");
  busy_len_a: assert property (busy |-> bcnt_q < 6'h19)
    else $error("busy held too long");
  busy_end_a: assert property ($fell(busy) |-> bcnt_q == 6'h19)
    else $error("busy window has the wrong length");
  quiet_busy_a: assert property (busy |-> !wr_stb)
    else $error("write during accept window");
  hi_order_a: assert property (wr_stb && wr_addr == 2'h2 |->
    $past(wr_stb && wr_addr == 2'h1)) else $error("high word without low");
  lo_follow_a: assert property (wr_stb && wr_addr == 2'h1 |=>
    wr_stb && (wr_addr == 2'h0 || wr_addr == 2'h2))
    else $error("low word not followed by high word or command");
  rd_hold_a: assert property ($stable(rd_addr) && !$past(wr_stb) |->
    $stable(rd_data)) else $error("read word changed on its own");
  // Main scenarios: a command, a four-byte value, a high-word read.
  cover property (take);
  cover property (wr_stb && wr_addr == 2'h2);
  cover property ($rose(rd_addr));
endmodule : motion_cmd_asserts
`default_nettype wire

//--- test/motion_command_parameter_decode_bench.sv
// Testbench: APB host sequencer and motion device joined by the link.
`timescale 1ns/1ps
`default_nettype none
`include "motion_regs.svh"
module motion_command_parameter_decode_bench;
  // APB and engine inputs, all idle at time zero.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic drive_active = 1'b0;
  // Device-side readback values; X and Y differ to expose axis slips.
  logic [1:0][31:0] lp = {32'h1111_2222, 32'h8765_4321};
  logic [1:0][31:0] ep = {32'h3333_4444, 32'hFEDC_BA98};
  logic [1:0][15:0] cv = {16'h0055, 16'h1F40};
  logic [1:0][15:0] ca = {16'h0066, 16'h0123};
  logic [31:0] peak = 32'h007F_FFFF;
  // Device outputs under test.
  logic [1:0][31:0] speed_multiple, accel_rate, decel_rate, start_velocity;
  logic [1:0][35:0] jerk_rate;
  logic [1:0][15:0] accel_count_offset;
  logic drive_go, interp_go, interp_step, pattern_push, pattern_clear;
  logic interp_irq_clear, peak_clear, pattern_wr_en, decel_enable;
  logic [2:0] drive_op;
  logic [1:0] drive_axes, interp_op;
  // S-curve pacing inputs and the levels they shape.
  logic [1:0] rstep = 2'b00, rdec = 2'b00, cspd;
  logic [1:0][15:0] ramp;
  // Scoreboard state.
  int error_cnt = 0;
  int num_checks = 0;
  int pcnt = 0;
  int cyc = 0;
  int n0;
  // Interpolation kind per code from 30h up; 31h is unused.
  logic [1:0] iop [5] = '{2'd0, 2'd0, 2'd1, 2'd2, 2'd3};
  logic [31:0] rq;
  logic [31:0] exp_rd [5];
  logic [7:0] codes [18] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h26, 8'h27, 8'h30, 8'h32, 8'h33, 8'h34, 8'h38, 8'h39, 8'h3A,
    8'h3D, 8'h3E, 8'h27};
  motion_bus_if link ();
  motion_cmd_host u_motion_cmd_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_active(drive_active), .bus(link));
  motion_cmd_device u_motion_cmd_device (.pclk(pclk), .presetn(presetn),
    .bus(link), .commanded_position_count(lp), .encoder_position_count(ep),
    .current_speed_value(cv), .current_accel_value(ca),
    .peak_endpoint_value(peak), .ramp_step(rstep), .ramp_clear(2'b00),
    .ramp_decel(rdec), .speed_multiple(speed_multiple),
    .jerk_rate(jerk_rate), .accel_rate(accel_rate), .decel_rate(decel_rate),
    .start_velocity(start_velocity), .drive_speed(),
    .accel_count_offset(accel_count_offset), .ramp_value(ramp),
    .constant_speed(cspd), .drive_ok(), .drive_go(drive_go),
    .drive_op(drive_op), .drive_axes(drive_axes), .interp_go(interp_go),
    .interp_op(interp_op), .interp_step(interp_step),
    .pattern_push(pattern_push), .pattern_clear(pattern_clear),
    .pattern_wr_en(pattern_wr_en), .decel_enable(decel_enable),
    .interp_irq_clear(interp_irq_clear), .peak_clear(peak_clear));
  motion_cmd_asserts u_motion_cmd_asserts (.pclk(pclk), .presetn(presetn),
    .wr_stb(link.wr_stb), .wr_addr(link.wr_addr), .wr_data(link.wr_data),
    .rd_addr(link.rd_addr), .rd_data(link.rd_data), .busy(link.busy));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Counts command pulses and cuts a hang short.
  always @(posedge pclk) begin
    pcnt <= pcnt + $countones({drive_go, interp_go, interp_step,
      pattern_push, pattern_clear, interp_irq_clear, peak_clear});
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task give_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Compares one value and reports a mismatch at once.
  task chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reads the status word until the sequencer is idle.
  task idle();
    do apb(1'b0, `A_STATUS, 32'h0); while (rq[`ST_BUSY] !== 1'b0);
  endtask : idle
  // Loads the data word, issues one command and waits for it to finish.
  task cmd(input logic [7:0] c, input logic [1:0] ax, input logic [31:0] d);
    apb(1'b1, `A_DATA, d);
    apb(1'b1, `A_CMD, {22'h0, ax, c});
    idle();
  endtask : cmd
  // Main sequence.
  initial begin
    exp_rd = '{lp[0], ep[0], {16'h0, cv[0]}, {16'h0, ca[0]}, peak};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(accel_count_offset, {2{`ACCOFS_RESET}});
    cmd(`C_DRV_FIRST, 2'b01, 32'h0);
    chk({pcnt[3:0], rq[`ST_NOTLOADED]}, 5'h01);
    cmd(`C_RANGE, 2'b11, 32'd16000);
    chk(speed_multiple, {32'd500, 32'd500});
    cmd(`C_RANGE, 2'b01, 32'd8000000);
    chk(speed_multiple, {32'd500, 32'd1});
    cmd(`C_ACCEL, 2'b10, 32'd8000);
    chk(accel_rate[1], 32'd500000000);
    cmd(`C_ACCEL, 2'b01, 32'd2);
    cmd(`C_JERK, 2'b01, 32'd1);
    chk(jerk_rate[0], 36'd62500000);
    cmd(`C_SVEL, 2'b01, 32'd100);
    chk(rq[`ST_LOWSV], 1'b1);
    cmd(`C_SVEL, 2'b11, 32'd300);
    chk(start_velocity, {32'd150000, 32'd300});
    cmd(`C_DSPEED, 2'b11, 32'd50);
    chk(cspd, 2'b11);
    apb(1'b1, `A_STATUS, 32'h0000_001E);
    cmd(`C_ACCEL, 2'b01, 32'd8001);
    cmd(8'h31, 2'b01, 32'h0);
    chk(rq[4:1], 4'b0011);
    chk(accel_rate[0], 32'd250);
    drive_active <= 1'b1;
    cmd(`C_RANGE, 2'b01, 32'd16000);
    chk(speed_multiple[0], 32'd1);
    drive_active <= 1'b0;
    apb(1'b1, `A_MODE3, 32'h0000_0002);
    cmd(`C_DECEL, 2'b01, 32'd4);
    chk(decel_rate[0], 32'd500);
    rstep <= 2'b01;
    repeat (4) @(posedge pclk);
    chk(ramp, {16'h0000, 16'h0002});
    rdec <= 2'b01;
    repeat (4) @(posedge pclk);
    chk(ramp, {16'h0000, 16'h0004});
    rstep <= 2'b00;
    apb(1'b1, `A_MODE3, 32'h0000_0000);
    idle();
    chk(decel_rate[0], 32'd250);
    foreach (codes[i]) begin
      n0 = pcnt;
      cmd(codes[i], 2'b11, 32'h0);
      chk(pcnt - n0, 1);
      if (codes[i] < 8'h28)
        chk({drive_axes, drive_op}, {2'b11, codes[i][2:0]});
      if (codes[i] inside {[8'h30:8'h34]})
        chk(interp_op, iop[codes[i] - 8'h30]);
    end
    cmd(`C_BP_EN, 2'b01, 32'h0);
    chk(pattern_wr_en, 1'b1);
    cmd(`C_BP_DIS, 2'b01, 32'h0);
    chk(pattern_wr_en, 1'b0);
    cmd(`C_DEC_DIS, 2'b01, 32'h0);
    chk(decel_enable, 1'b0);
    cmd(`C_DEC_EN, 2'b01, 32'h0);
    chk(decel_enable, 1'b1);
    for (int i = 0; i < 5; i++) begin
      cmd(`C_RD_LP + 8'(i), 2'b01, 32'h0);
      apb(1'b0, `A_RDATA, 32'h0);
      chk(rq, exp_rd[i]);
    end
    cmd(`C_RD_LP, 2'b10, 32'h0);
    apb(1'b0, `A_RDATA, 32'h0);
    chk(rq, lp[1]);
    apb(1'b0, 12'h020, 32'h0);
    chk({pslverr, rq}, {1'b1, 32'h0});
    give_verdict();
  end
endmodule : motion_command_parameter_decode_bench
`default_nettype wire
